// ==== rtl/iad_io_alarm_diag.sv ====
// I/O line, data-ready, DAC, test trigger, status and alarm registers.
// Assumes a host on a mode-3 serial port and datapath inputs on clk.
// Overview of operation
// - Low nibble sets line directions, bits 11:8 their levels.
// - Default configuration drives line 1 as active-high data ready.
// - Data-ready pulse lasts between 100 and 200 microseconds.
// - Misc bits 2,1,0 give data-ready enable, polarity and line.
// - Misc bit 11 runs memory check into status bit 6, then clears.
// - Misc bit 10 runs self-test, reports flags, then clears itself.
// - Misc bits 9 and 8 apply negative and positive test stimulus.
// - Misc bits 7 and 6 enable bias compensation and origin alignment.
// - DAC value moves to DAC input only on latch command.
// - DAC register holds 12-bit offset binary code in low bits.
// - Status flags clear on read and return next sample if persisting.
// - Supply flags clear by themselves once supply is in range.
// - Status bits 15,14,13,10 flag accelerometer and rate self-test fail.
// - Status bits 9,8 alarms; 5,4,3,2 test, overrange, serial, flash.
// - Status bit 1 high supply, bit 0 low supply.
// - Threshold bit 15 compare polarity, bits 13:0 threshold.
// - Sample count is 8 bits; zero and one both mean one sample.
// - Rate-of-change period is sample count times sample period.
// - Alarm control bits 15:12 and 11:8 pick alarm sources.
// - Bits 7,6 pick rate-of-change; bit 4 filtered; inclines filtered.
// - Alarm control bits 2,1,0 give output enable, polarity, line.
// - Line claims rank misc control, then alarm control, then I/O.
// - Error-active flag is high while any status flag is set.
`timescale 1ns/1ps
module iad_io_alarm_diag
  import iad_pkg::*;
#(
  parameter int TB_FAST_CYC = TB_FAST_DEF,
  parameter int TB_SLOW_CYC = TB_SLOW_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial port
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // I/O lines 1..4 at bits 0..3
  input  wire logic [3:0]  io_line_i,
  output logic      [3:0]  io_line_o,
  output logic      [3:0]  io_line_oe,
  // Datapath side
  input  wire iad_src_s    src,
  input  wire iad_test_s   tst,
  input  wire iad_cond_s   cond,
  output logic             st_start,
  output logic             mt_start,
  output logic      [1:0]  st_stim,
  output logic             bias_comp_en,
  output logic             origin_align_en,
  output logic      [11:0] dac_code,
  output logic             sample_tick,
  output logic             error_active_flag
);

  // Pin synchronisers: a change counts once stages two and three agree
  logic [6:0] pin_in;
  logic [6:0] s1_ff, s2_ff, s3_ff, flt_ff, flt_d_ff;
  assign pin_in = {cs_n, sclk, din, io_line_i};
  genvar gp;
  generate
    for (gp = 0; gp < 7; gp++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_ff[gp]    <= 1'b1;
          s2_ff[gp]    <= 1'b1;
          s3_ff[gp]    <= 1'b1;
          flt_ff[gp]   <= 1'b1;
          flt_d_ff[gp] <= 1'b1;
        end else begin
          s1_ff[gp]    <= pin_in[gp];
          s2_ff[gp]    <= s1_ff[gp];
          s3_ff[gp]    <= s2_ff[gp];
          flt_d_ff[gp] <= flt_ff[gp];
          if (s2_ff[gp] == s3_ff[gp]) flt_ff[gp] <= s3_ff[gp];
        end
      end
    end
  endgenerate

  wire       cs_fall   = flt_d_ff[6] & ~flt_ff[6];
  wire       cs_rise   = ~flt_d_ff[6] & flt_ff[6];
  wire       in_frame  = ~flt_ff[6];
  wire       sck_rise  = in_frame & ~flt_d_ff[5] & flt_ff[5];
  wire       sck_fall  = in_frame & flt_d_ff[5] & ~flt_ff[5];
  wire       din_s     = flt_ff[4];
  wire [3:0] io_s      = flt_ff[3:0];
  wire       io4_rise  = io_s[3] & ~flt_d_ff[3];

  // Registers
  logic [15:0] rx_ff, tx_ff;
  logic [4:0]  bit_cnt_ff;
  logic [15:0] io_ctrl_ff, misc_ff, dac_reg_ff, diag_ff, alarm_control_ff;
  logic [1:0][15:0] thr_ff;
  logic [1:0][7:0]  cnt_reg_ff;
  logic [7:0]  sample_period_ff;
  logic        dout_oe_ff, st_start_ff, mt_start_ff, ea_ff, tick_ff;
  logic [11:0] dac_ff;
  logic [3:0]  io_o_ff, io_oe_ff;

  // Command decode at frame end
  wire        frame_ok  = cs_rise & (bit_cnt_ff == FRAME_BITS);
  wire        bad_frame = cs_rise & (bit_cnt_ff != FRAME_BITS) &
                          (bit_cnt_ff != 5'h00);
  wire        cmd_wr    = frame_ok & rx_ff[CMD_WR_BIT];
  wire        cmd_rd    = frame_ok & ~rx_ff[CMD_WR_BIT];
  wire [6:0]  cmd_addr  = rx_ff[14:8];
  wire [7:0]  cmd_data  = rx_ff[7:0];
  wire        cmd_hi    = cmd_addr[0];
  wire [6:0]  word_addr = {cmd_addr[6:1], 1'b0};
  wire        diag_rd   = cmd_rd & (word_addr == ADDR_DIAG);

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic        hi,
                                        input logic [7:0]  dat,
                                        input logic [15:0] mask);
    logic [15:0] tmp;
    tmp = hi ? {dat, old_v[7:0]} : {old_v[15:8], dat};
    merge = tmp & mask;
  endfunction : merge

  function automatic logic wr_to(input logic [6:0] base);
    wr_to = cmd_wr & (word_addr == base);
  endfunction : wr_to

  // Read path: input lines report their pin levels
  logic [15:0] io_rd;
  assign io_rd = {4'h0, (io_ctrl_ff[11:8] & io_ctrl_ff[3:0]) |
                  (io_s & ~io_ctrl_ff[3:0]), 4'h0, io_ctrl_ff[3:0]};
  logic [15:0] rd_word;
  always_comb begin
    case (word_addr)
      ADDR_ALM_THR1: rd_word = thr_ff[0];
      ADDR_ALM_THR2: rd_word = thr_ff[1];
      ADDR_ALM_CNT1: rd_word = {8'h00, cnt_reg_ff[0]};
      ADDR_ALM_CNT2: rd_word = {8'h00, cnt_reg_ff[1]};
      ADDR_ALARM_CONTROL: rd_word = alarm_control_ff;
      ADDR_DAC:      rd_word = dac_reg_ff;
      ADDR_IO_CTRL:  rd_word = io_rd;
      ADDR_MISC:     rd_word = misc_ff;
      ADDR_SAMPLE_PERIOD: rd_word = {8'h00, sample_period_ff};
      ADDR_DIAG:     rd_word = diag_ff;
      default:       rd_word = 16'h0000;
    endcase
  end

  // Serial shifter; reply to a read leaves in the next frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_ff      <= 16'h0000;
      tx_ff      <= 16'h0000;
      bit_cnt_ff <= 5'h00;
      dout_oe_ff <= 1'b0;
    end else begin
      dout_oe_ff <= in_frame;
      if (cs_fall) bit_cnt_ff <= 5'h00;
      else if (sck_rise && bit_cnt_ff != 5'h1F) bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (sck_rise) rx_ff <= {rx_ff[14:0], din_s};
      if (frame_ok) tx_ff <= cmd_rd ? rd_word : 16'h0000;
      else if (sck_fall && bit_cnt_ff != 5'h00) tx_ff <= {tx_ff[14:0], 1'b0};
    end
  end

  // Sample timing: internal base counter or external clock on line 4
  logic [18:0] base_cnt_ff;
  logic [6:0]  mul_cnt_ff;
  wire  [18:0] base_len = sample_period_ff[SP_TB_BIT] ? 19'(TB_SLOW_CYC) :
                                                   19'(TB_FAST_CYC);
  // External clock: line 4 input and zero period
  wire         ext_clk  = (sample_period_ff == 8'h00) & ~io_ctrl_ff[3];
  wire         base_end = (base_cnt_ff >= base_len - 19'h1);
  wire         int_tick = base_end & (mul_cnt_ff >= sample_period_ff[6:0]);
  wire         tick     = ext_clk ? io4_rise : int_tick;
  always_ff @(posedge clk) begin
    if (!rst_n || ext_clk) begin
      base_cnt_ff <= 19'h0;
      mul_cnt_ff  <= 7'h0;
    end else if (base_end) begin
      base_cnt_ff <= 19'h0;
      mul_cnt_ff  <= int_tick ? 7'h0 : mul_cnt_ff + 7'h1;
    end else begin
      base_cnt_ff <= base_cnt_ff + 19'h1;
    end
  end

  logic [11:0] dr_cnt_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) dr_cnt_ff <= 12'h000;
    else if (tick) dr_cnt_ff <= DR_CYC;
    else if (dr_cnt_ff != 12'h000) dr_cnt_ff <= dr_cnt_ff - 12'h001;
  end
  wire dr_active = (dr_cnt_ff != 12'h000);

  // Alarms, one generate entry each
  logic [1:0] alm_act_ff;
  genvar ga;
  generate
    for (ga = 0; ga < 2; ga++) begin : g_alarm
      logic [7:0]  per_ff;
      logic [13:0] ref_ff;
      wire [3:0]  sel  = alarm_control_ff[ALM_SRC1_LO + 4*ga +: 4];
      wire        on   = (sel != SRC_OFF) && (sel != SRC_NONE_A) &&
                         (sel != SRC_NONE_B) && (sel < 4'(SRC_N));
      wire        filt = alarm_control_ff[ALM_FILT] || (sel == SRC_INCL_X) ||
                         (sel == SRC_INCL_Y);
      wire [13:0] val  = on ? (filt ? src.filt[sel] : src.raw[sel]) : 14'h0;
      wire        rate_of_change  = alarm_control_ff[ALM_ROC1 + ga];
      wire signed [14:0] thr  = {thr_ff[ga][13], thr_ff[ga][13:0]};
      // Sign-extend first so the difference cannot wrap
      wire signed [14:0] cur  = rate_of_change ? signed'({val[13], val} -
                                              {ref_ff[13], ref_ff}) :
                                      {val[13], val};
      wire        hit  = thr_ff[ga][THR_POL] ? (cur > thr) : (cur < thr);
      // zero and one both one sample
      wire [7:0]  n    = (cnt_reg_ff[ga] == 8'h00) ? 8'h01 : cnt_reg_ff[ga];
      wire        pend = (per_ff >= n - 8'h01);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          per_ff         <= 8'h00;
          ref_ff         <= 14'h0;
          alm_act_ff[ga] <= 1'b0;
        end else if (!on) begin
          per_ff         <= 8'h00;
          alm_act_ff[ga] <= 1'b0;
        end else if (tick) begin
          if (!rate_of_change || pend) alm_act_ff[ga] <= hit;
          per_ff <= (rate_of_change && !pend) ? per_ff + 8'h01 : 8'h00;
          if (!rate_of_change || pend) ref_ff <= val;
        end
      end
    end
  endgenerate
  wire alarm_any = |alm_act_ff;

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_ctrl_ff  <= 16'h0000;
      misc_ff     <= MISC_RST;
      dac_reg_ff  <= 16'h0000;
      alarm_control_ff <= 16'h0000;
      thr_ff      <= '0;
      cnt_reg_ff  <= '0;
      sample_period_ff <= SMPL_RST;
      st_start_ff <= 1'b0;
      mt_start_ff <= 1'b0;
      dac_ff      <= 12'h000;
    end else begin
      st_start_ff <= 1'b0;
      mt_start_ff <= 1'b0;
      if (wr_to(ADDR_IO_CTRL))
        io_ctrl_ff <= merge(io_ctrl_ff, cmd_hi, cmd_data, IO_MASK);
      if (wr_to(ADDR_MISC)) begin
        misc_ff <= merge(misc_ff, cmd_hi, cmd_data, MISC_MASK);
        if (cmd_hi && cmd_data[MISC_MEMTST-8] && !misc_ff[MISC_MEMTST])
          mt_start_ff <= 1'b1;
        if (cmd_hi && cmd_data[MISC_ST_AUTO-8] && !misc_ff[MISC_ST_AUTO])
          st_start_ff <= 1'b1;
      end else begin
        if (tst.mt_done) misc_ff[MISC_MEMTST] <= 1'b0;
        if (tst.st_done) misc_ff[MISC_ST_AUTO] <= 1'b0;
      end
      if (wr_to(ADDR_DAC))
        dac_reg_ff <= merge(dac_reg_ff, cmd_hi, cmd_data, DAC_MASK);
      if (wr_to(ADDR_GLOBAL_COMMAND) && !cmd_hi && cmd_data[GLOB_DAC_LAT])
        dac_ff <= dac_reg_ff[11:0];
      if (wr_to(ADDR_ALARM_CONTROL))
        alarm_control_ff <= merge(alarm_control_ff, cmd_hi, cmd_data, ALARM_CONTROL_MASK);
      if (wr_to(ADDR_ALM_THR1))
        thr_ff[0] <= merge(thr_ff[0], cmd_hi, cmd_data, THR_MASK);
      if (wr_to(ADDR_ALM_THR2))
        thr_ff[1] <= merge(thr_ff[1], cmd_hi, cmd_data, THR_MASK);
      if (wr_to(ADDR_ALM_CNT1) && !cmd_hi) cnt_reg_ff[0] <= cmd_data;
      if (wr_to(ADDR_ALM_CNT2) && !cmd_hi) cnt_reg_ff[1] <= cmd_data;
      if (wr_to(ADDR_SAMPLE_PERIOD) && !cmd_hi) sample_period_ff <= cmd_data;
    end
  end

  // Status flags: a set in the clearing cycle wins
  logic [15:0] diag_set, diag_clr;
  always_comb begin
    diag_set = 16'h0000;
    if (tst.st_done) begin
      diag_set[15:DG_X_ST]   = tst.st_fail[3:1];
      diag_set[DG_GYRO_ST]   = tst.st_fail[0];
      diag_set[DG_ST_ERR]    = |tst.st_fail;
    end
    diag_set[DG_MEM]         = tst.mt_done & tst.mt_fail;
    // serial failure on a short or long frame
    diag_set[DG_SPI_FAIL]    = bad_frame;
    if (tick) begin
      diag_set[DG_ALM1 +: 2] = alm_act_ff;
      diag_set[DG_OVR]       = cond.overrange;
      diag_set[DG_FLASH_UPD] = cond.flash_upd_fail;
      diag_set[DG_SUP_HI]    = cond.supply_hi;
      diag_set[DG_SUP_LO]    = cond.supply_lo;
    end
    diag_clr = {16{diag_rd}};
    // supply flags drop when back in range
    diag_clr[DG_SUP_HI] = diag_rd | ~cond.supply_hi;
    diag_clr[DG_SUP_LO] = diag_rd | ~cond.supply_lo;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) diag_ff <= 16'h0000;
    else diag_ff <= (diag_ff & ~diag_clr | diag_set) & 16'hE77F;
  end

  // Line ownership
  logic [3:0] nxt_io_o, nxt_io_oe;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_line
      wire dr_own = (gl < 2) && misc_ff[MISC_DR_EN] &&
                    (misc_ff[MISC_DR_LINE] == 1'(gl));
      wire al_own = (gl < 2) && alarm_control_ff[ALM_OUT_EN] &&
                    (alarm_control_ff[ALM_LINE] == 1'(gl));
      assign nxt_io_oe[gl] = dr_own | al_own | io_ctrl_ff[gl];
      assign nxt_io_o[gl]  =
        dr_own ? ~(dr_active ^ misc_ff[MISC_DR_POL]) :
        al_own ? ~(alarm_any ^ alarm_control_ff[ALM_POL]) :
                 io_ctrl_ff[8 + gl];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_o_ff  <= 4'h0;
      io_oe_ff <= 4'h0;
      ea_ff    <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      io_o_ff  <= nxt_io_o;
      io_oe_ff <= nxt_io_oe;
      ea_ff    <= |diag_ff;
      tick_ff  <= tick;
    end
  end

  assign dout              = tx_ff[15];
  assign dout_oe           = dout_oe_ff;
  assign io_line_o         = io_o_ff;
  assign io_line_oe        = io_oe_ff;
  assign st_start          = st_start_ff;
  assign mt_start          = mt_start_ff;
  assign st_stim           = misc_ff[MISC_ST_NEG:MISC_ST_POS];
  assign bias_comp_en      = misc_ff[MISC_BIASC];
  assign origin_align_en   = misc_ff[MISC_ORIGIN];
  assign dac_code          = dac_ff;
  assign sample_tick       = tick_ff;
  assign error_active_flag = ea_ff;

  // Checks
  localparam int DRMIN = DR_MIN_CYC;
  localparam int DRMAX = DR_MAX_CYC;
  logic [12:0] dr_len_ff;
  always_ff @(posedge clk) begin
    if (!rst_n || !dr_active) dr_len_ff <= 13'h0;
    else dr_len_ff <= dr_len_ff + 13'h1;
  end
  sequence dr_end_s;
    dr_active ##1 !dr_active;
  endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  dr_width_a: assert property (dr_end_s |->
    (dr_len_ff >= 13'(DRMIN - 1)) && (dr_len_ff <= 13'(DRMAX)))
    else $error("data ready width out of range");
  dr_default_a: assert property ($rose(dr_active) &&
    misc_ff[2:0] == MISC_RST[2:0] |=> io_line_o[0] && io_line_oe[0])
    else $error("default data ready missing on line 1");
  dr_polarity_a: assert property (dr_active && misc_ff[MISC_DR_EN] &&
    !misc_ff[MISC_DR_POL] && misc_ff[MISC_DR_LINE] ##1 dr_active
    |-> !io_line_o[1] && io_line_oe[1])
    else $error("active low data ready wrong");
  line_prio_a: assert property (misc_ff[MISC_DR_EN] &&
    alarm_control_ff[ALM_OUT_EN] && !misc_ff[0] && !alarm_control_ff[0] &&
    misc_ff[1] && !dr_active |=> !io_line_o[0])
    else $error("alarm overrode data ready");
  io_level_a: assert property (io_ctrl_ff[3] &&
    !ext_clk |=> io_line_oe[3] && io_line_o[3] == $past(io_ctrl_ff[11]))
    else $error("line 4 output level wrong");
  memtest_a: assert property (tst.mt_done && tst.mt_fail &&
    !wr_to(ADDR_MISC) |=> diag_ff[DG_MEM] && !misc_ff[MISC_MEMTST])
    else $error("memory test result lost");
  selftest_a: assert property (tst.st_done && tst.st_fail[0] &&
    !wr_to(ADDR_MISC) |=> diag_ff[DG_GYRO_ST] && diag_ff[DG_ST_ERR] &&
    !misc_ff[MISC_ST_AUTO])
    else $error("self test not reported");
  dac_hold_a: assert property (!wr_to(ADDR_GLOBAL_COMMAND) |=>
    $stable(dac_code))
    else $error("dac moved without latch");
  diag_clear_a: assert property (diag_rd && !tick && !tst.st_done &&
    !tst.mt_done |=> diag_ff == 16'h0000)
    else $error("status not cleared by read");
  supply_auto_a: assert property (!cond.supply_hi |=>
    !diag_ff[DG_SUP_HI])
    else $error("high supply flag stuck");
  ea_flag_a: assert property ((|diag_ff) |=> error_active_flag)
    else $error("error active flag missing");

endmodule : iad_io_alarm_diag

// ==== shared/iad_pkg.sv ====
// Package for the I/O, alarm and diagnostic register block.
// Assumes a 20 MHz system clock and 16-bit serial command words.
package iad_pkg;

  // Clock and timing
  localparam int          CLK_MHZ     = 20;
  localparam int          TB_FAST_NS  = 610350;
  localparam int          TB_SLOW_NS  = 18921000;
  localparam int          DR_MIN_US   = 100;
  localparam int          DR_MAX_US   = 200;
  localparam int          TB_FAST_DEF = TB_FAST_NS * CLK_MHZ / 1000;
  localparam int          TB_SLOW_DEF = TB_SLOW_NS * CLK_MHZ / 1000;
  localparam int          DR_MIN_CYC  = (DR_MIN_US * CLK_MHZ);
  localparam int          DR_MAX_CYC  = (DR_MAX_US * CLK_MHZ);
  localparam logic [11:0] DR_CYC      = 12'(DR_MIN_CYC);

  // Frame
  localparam logic [4:0]  FRAME_BITS  = 5'h10;
  localparam int          CMD_WR_BIT  = 15;

  // Byte addresses, low byte of each word
  localparam logic [6:0]  ADDR_ALM_THR1  = 7'h26;
  localparam logic [6:0]  ADDR_ALM_THR2  = 7'h28;
  localparam logic [6:0]  ADDR_ALM_CNT1  = 7'h2A;
  localparam logic [6:0]  ADDR_ALM_CNT2  = 7'h2C;
  localparam logic [6:0]  ADDR_ALARM_CONTROL  = 7'h2E;
  localparam logic [6:0]  ADDR_DAC       = 7'h30;
  localparam logic [6:0]  ADDR_IO_CTRL   = 7'h32;
  localparam logic [6:0]  ADDR_MISC      = 7'h34;
  localparam logic [6:0]  ADDR_SAMPLE_PERIOD  = 7'h36;
  localparam logic [6:0]  ADDR_DIAG      = 7'h3C;
  localparam logic [6:0]  ADDR_GLOBAL_COMMAND  = 7'h3E;

  // Field positions
  localparam int MISC_DR_LINE = 0;
  localparam int MISC_DR_POL  = 1;
  localparam int MISC_DR_EN   = 2;
  localparam int MISC_ORIGIN  = 6;
  localparam int MISC_BIASC   = 7;
  localparam int MISC_ST_POS  = 8;
  localparam int MISC_ST_NEG  = 9;
  localparam int MISC_ST_AUTO = 10;
  localparam int MISC_MEMTST  = 11;
  localparam int ALM_LINE     = 0;
  localparam int ALM_POL      = 1;
  localparam int ALM_OUT_EN   = 2;
  localparam int ALM_FILT     = 4;
  localparam int ALM_ROC1     = 6;
  localparam int ALM_SRC1_LO  = 8;
  localparam int THR_POL      = 15;
  localparam int GLOB_DAC_LAT = 2;
  localparam int SP_TB_BIT    = 7;
  localparam int DG_SUP_LO    = 0;
  localparam int DG_SUP_HI    = 1;
  localparam int DG_FLASH_UPD = 2;
  localparam int DG_SPI_FAIL  = 3;
  localparam int DG_OVR       = 4;
  localparam int DG_ST_ERR    = 5;
  localparam int DG_MEM       = 6;
  localparam int DG_ALM1      = 8;
  localparam int DG_GYRO_ST   = 10;
  localparam int DG_X_ST      = 13;

  // Reset values and masks
  localparam logic [15:0] MISC_RST      = 16'h0006;
  localparam logic [15:0] MISC_MASK     = 16'h0FC7;
  localparam logic [15:0] IO_MASK       = 16'h0F0F;
  localparam logic [15:0] THR_MASK      = 16'hBFFF;
  localparam logic [15:0] ALARM_CONTROL_MASK = 16'hFFD7;
  localparam logic [15:0] DAC_MASK      = 16'h0FFF;
  localparam logic [7:0]  SMPL_RST      = 8'h01;

  // Alarm source codes
  localparam logic [3:0]  SRC_OFF    = 4'h0;
  localparam logic [3:0]  SRC_NONE_A = 4'h3;
  localparam logic [3:0]  SRC_NONE_B = 4'h4;
  localparam logic [3:0]  SRC_INCL_X = 4'h9;
  localparam logic [3:0]  SRC_INCL_Y = 4'hA;
  localparam int          SRC_N      = 12;

  typedef struct packed {
    logic [SRC_N-1:0][13:0] raw;
    logic [SRC_N-1:0][13:0] filt;
  } iad_src_s;

  typedef struct packed {
    logic       st_done;
    logic [3:0] st_fail;
    logic       mt_done;
    logic       mt_fail;
  } iad_test_s;

  typedef struct packed {
    logic supply_hi;
    logic supply_lo;
    logic overrange;
    logic flash_upd_fail;
  } iad_cond_s;

endpackage : iad_pkg

// ==== tb/iad_host_model.sv ====
// Host model: mode-3 serial master, 16-bit frames.
// Assumes clk of the block; sclk idles high between frames.
`timescale 1ns/1ps
module iad_host_model (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end
  // Half periods of 4 clk, reply bits taken before each fall
  task automatic xfer(input logic [15:0] w, output logic [15:0] q);
    q = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din  <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      q[i] = dout;
    end
    cs_n <= 1'b1;
    // Released data line must not keep the last bit
    din  <= ~w[0];
    repeat (10) @(posedge clk);
  endtask : xfer
endmodule : iad_host_model

// ==== tb/iad_io_alarm_diag_tb.sv ====
// Bench: register block driven through the host serial model.
// Assumes shortened time bases; pin inputs of the lines read 0 until line 4 is driven high as the external clock.
`timescale 1ns/1ps
module iad_io_alarm_diag_tb;
  import iad_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, din, dout, dout_oe, st_start, mt_start;
  logic        bias_comp_en, origin_align_en, sample_tick;
  logic        error_active_flag, got_v = 1'b0;
  logic [3:0]  io_line_i, io_line_o, io_line_oe;
  logic [1:0]  st_stim;
  logic [11:0] dac_code, v;
  logic [15:0] r, got_d, exq[$];
  iad_src_s    src;
  iad_test_s   tst;
  iad_cond_s   cond;
  int          n_mismatch = 0, n_compared = 0, seed = 84, n;
  int          n_start = 0;
  always #25 clk = ~clk;
  iad_io_alarm_diag #(.TB_FAST_CYC(1500), .TB_SLOW_CYC(3000))
    i_iad_io_alarm_diag (.clk, .rst_n, .cs_n, .sclk, .din, .dout,
    .dout_oe, .io_line_i, .io_line_o, .io_line_oe, .src, .tst, .cond,
    .st_start, .mt_start, .st_stim, .bias_comp_en, .origin_align_en,
    .dac_code, .sample_tick, .error_active_flag);
  iad_host_model i_iad_host_model (.clk, .cs_n, .sclk, .din, .dout);
  always @(posedge clk) begin
    if (got_v === 1'b1) begin
      n_compared++;
      if (exq[0] !== got_d) begin
        n_mismatch++;
        $display("Error at %0t: got %h, want %h", $time, got_d, exq[0]);
      end
      exq.delete(0);
    end
  end
  // Both test starts must pulse on the same trigger write
  always @(posedge clk) begin
    if (st_start === 1'b1 && mt_start === 1'b1) n_start++;
  end
  task automatic conclude();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic note(input logic [15:0] e, input logic [15:0] a);
    exq.push_back(e);
    got_d <= a;
    got_v <= 1'b1;
    @(posedge clk);
    got_v <= 1'b0;
    @(posedge clk);
  endtask : note
  task automatic wt(input int k);
    if (k >= 8000) begin
      n_mismatch++;
      $display("Error at %0t: wait ran out", $time);
      conclude();
    end
  endtask : wt
  task automatic ticks(input int t);
    repeat (t) begin
      n = 0;
      @(negedge clk);
      while (sample_tick !== 1'b1 && n < 8000) begin
        @(negedge clk);
        n++;
      end
      wt(n);
    end
  endtask : ticks
  task automatic until_dr(input logic lv);
    n = 0;
    while (io_line_o[0] === lv && n < 8000) begin
      @(negedge clk);
      n++;
    end
    wt(n);
  endtask : until_dr
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] q;
    i_iad_host_model.xfer({1'b1, a, d}, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    i_iad_host_model.xfer({1'b0, a, 8'h00}, q);
    i_iad_host_model.xfer(16'h0000, q);
  endtask : rd
  initial begin
    {src, tst, cond, io_line_i} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ADDR_MISC, r);
    note(MISC_RST, r);
    ticks(1);
    v = {10'h0, io_line_oe[0], io_line_o[0]};
    until_dr(1'b0);
    until_dr(1'b1);
    note(16'h0002, {4'h0, v});
    note(16'h0001, 16'(n >= DR_MIN_CYC && n <= DR_MAX_CYC));
    $display("Test data ready done");
    wr(ADDR_IO_CTRL, 8'h0C);
    wr(ADDR_IO_CTRL + 7'h1, 8'h08);
    note(16'h00D8, {8'h0, io_line_oe, io_line_o[3:2], 2'b00});
    $display("Test io lines done");
    v = 12'($random(seed));
    wr(ADDR_DAC, v[7:0]);
    wr(ADDR_DAC + 7'h1, {4'h0, v[11:8]});
    note(16'h0000, {4'h0, dac_code});
    wr(ADDR_GLOBAL_COMMAND, 8'h04);
    note({4'h0, v}, {4'h0, dac_code});
    rd(ADDR_DAC, r);
    note({4'h0, v}, r);
    $display("Test dac done");
    wr(ADDR_MISC, 8'hC6);
    wr(ADDR_MISC + 7'h1, 8'h03);
    note(16'h000F, {12'h0, st_stim, bias_comp_en, origin_align_en});
    wr(ADDR_MISC + 7'h1, 8'h0C);
    tst <= {1'b1, 4'b0001, 1'b1, 1'b1};
    @(posedge clk);
    tst <= '0;
    rd(ADDR_MISC, r);
    note(16'h00C6, r);
    note(16'h0001, 16'(n_start));
    rd(ADDR_DIAG, r);
    note(16'h0440, r & 16'hE440);
    $display("Test self tests done");
    cond <= 4'b0110;
    ticks(1);
    // Error-active trails the status word by one clock
    @(negedge clk);
    note(16'h0001, {15'h0, error_active_flag});
    @(posedge clk);
    cond <= 4'b0010;
    rd(ADDR_DIAG, r);
    note(16'h0010, r & 16'h0013);
    ticks(1);
    rd(ADDR_DIAG, r);
    note(16'h0010, r & 16'h0010);
    @(posedge clk);
    cond <= 4'b0000;
    rd(ADDR_DIAG, r);
    rd(ADDR_DIAG, r);
    note(16'h0000, r);
    note(16'h0000, {15'h0, error_active_flag});
    $display("Test status done");
    wr(ADDR_ALM_THR1 + 7'h1, 8'h80);
    wr(ADDR_ALM_THR1, 8'h64);
    wr(ADDR_ALARM_CONTROL + 7'h1, 8'h05);
    wr(ADDR_ALARM_CONTROL, 8'h07);
    src.raw[5] <= 14'd200;
    ticks(2);
    note(16'h0003, {14'h0, io_line_oe[1], io_line_o[1]});
    rd(ADDR_DIAG, r);
    note(16'h0100, r & 16'h0300);
    src.raw[5] <= 14'd50;
    ticks(2);
    note(16'h0002, {14'h0, io_line_oe[1], io_line_o[1]});
    $display("Test alarm done");
    wr(ADDR_IO_CTRL, 8'h04);
    wr(ADDR_SAMPLE_PERIOD, 8'h00);
    io_line_i <= 4'h8;
    ticks(1);
    note(16'h0001, 16'(n < 20));
    $display("Test external clock done");
    conclude();
  end
endmodule : iad_io_alarm_diag_tb
